// ### logic/mac_pkg.sv
// Purpose: shared constants for the acquisition sequencer
// Assumes: one 25 MHz clock; all pins synchronous to it
// Notes:   mode and clock-source encodings are local choices
package mac_pkg;
    localparam int CH_N       = 4;
    localparam int GAIN_W     = 2;
    localparam int DATA_W     = 12;
    localparam int CNT_W      = 17;
    localparam int DIV_W      = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW    = 4;

    // gain codes: 1, 2, 5, 10 -> spans 5, 2.5, 1, 0.5 volts
    localparam logic [1:0] GAIN_X1  = 2'h0;
    localparam logic [1:0] GAIN_X2  = 2'h1;
    localparam logic [1:0] GAIN_X5  = 2'h2;
    localparam logic [1:0] GAIN_X10 = 2'h3;

    localparam logic [2:0] MODE_SINGLE = 3'h0;
    localparam logic [2:0] MODE_PACER  = 3'h1;
    localparam logic [2:0] MODE_POST   = 3'h2;
    localparam logic [2:0] MODE_DELAY  = 3'h3;
    localparam logic [2:0] MODE_ABOUT  = 3'h4;
    localparam logic [2:0] MODE_PRE    = 3'h5;

    localparam logic [1:0] CLK_INTERNAL = 2'h0;
    localparam logic [1:0] CLK_EXT_DIFF = 2'h1;
    localparam logic [1:0] CLK_EXT_SE   = 2'h2;

    localparam logic [1:0] TRG_SOFT   = 2'h0;
    localparam logic [1:0] TRG_EXT    = 2'h1;
    localparam logic [1:0] TRG_ANALOG = 2'h2;

    localparam logic [DIV_W-1:0] DIV_RESET = 8'hff;
    localparam logic [CNT_W-1:0] CNT_ONE   = 17'h00001;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 17'h00000;
    localparam logic [CNT_W-1:0] CNT_TWO   = 17'h00002;

    typedef enum logic [4:0] {
        MAC_IDLE  = 5'b00001,
        MAC_WAIT  = 5'b00010,
        MAC_DELAY = 5'b00100,
        MAC_RUN   = 5'b01000,
        MAC_POST  = 5'b10000
    } mac_state_e;
endpackage : mac_pkg

// ### logic/mac_acq.sv
// Purpose: acquisition sequencer, clock select and result buffer for a 4-channel A/D card
// Assumes: mclk at 25 MHz stands for the time base; converter answers with conv_done
// Notes:   results pass through a two-entry buffer; circular mode drops oldest words
//
// How it works
// - each channel has its own two-bit gain code: 1, 2, 5 or 10
// - six modes: single, pacer, post, delay, about and pre trigger
// - single mode: one software trigger gives one conversion into the fifo
// - pacer mode converts on every sample clock edge while the clock runs
// - paced and triggered modes take internal divider or either external clock
// - post trigger: start on trigger, stop at count n or software stop
// - delay trigger: skip m sample clocks after trigger, then store n samples
// - about trigger: sample from first edge, then stop once m words are stored after trigger, in-flight ones included
// - about trigger ends holding the latest 16 samples around the trigger
// - pre trigger: sample from start, stop at trigger, keep earlier samples
// - internal sample clock is an 8-bit divider; conversion on its rising edge
// - divider spans full rate (divisor 0) to 1/256 of the time base
// - differential external clock limits conversion rate to half its frequency
// - two external clocks: differential-derived and single-ended
// - hot reset keeps or clears configuration as the jumper says
// - trigger from software, external logic level or analog threshold
// - trigger edge programmable rising or falling
`timescale 1ns/1ps
`default_nettype none
module mac_acq
    import mac_pkg::*;
(
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire logic                      hot_reset,
    input  wire logic                      hot_reset_config_jumper,
    input  wire logic                      cfg_we,
    input  wire logic [2:0]                cfg_mode,
    input  wire logic [1:0]                cfg_clk_src,
    input  wire logic [1:0]                cfg_trg_src,
    input  wire logic                      cfg_trg_falling,
    input  wire logic [DIV_W-1:0]          cfg_divisor,
    input  wire logic [CH_N*GAIN_W-1:0]    cfg_gain,
    input  wire logic [CNT_W-1:0]          cfg_count_n,
    input  wire logic [CNT_W-1:0]          cfg_count_m,
    input  wire logic                      cfg_dma_en,
    input  wire logic                      sw_start,
    input  wire logic                      sw_stop,
    input  wire logic                      sw_trigger,
    input  wire logic                      ext_trigger,
    input  wire logic                      analog_above,
    input  wire logic                      differential_ext_sample_clock,
    input  wire logic                      single_ended_ext_sample_clock,
    output logic                           conv_start,
    input  wire logic                      conv_done,
    input  wire logic [DATA_W-1:0]         conv_data,
    output logic [CH_N*GAIN_W-1:0]         gain_out,
    input  wire logic                      rd_en,
    output logic [DATA_W-1:0]              rd_data,
    output logic                           fifo_not_empty,
    output logic                           fifo_full,
    output logic                           acq_busy,
    output logic                           acq_done,
    output logic                           dma_err
);
    import mac_pkg::*;

    function automatic logic [FIFO_AW-1:0] ptr_inc(input logic [FIFO_AW-1:0] p);
        ptr_inc = p + {{(FIFO_AW-1){1'b0}}, 1'b1};
    endfunction : ptr_inc

    // configuration; jumper high keeps it through a hot reset
    logic [2:0]             mode_r;
    logic [1:0]             clk_src_r;
    logic [1:0]             trg_src_r;
    logic                   trg_fall_r;
    logic [DIV_W-1:0]       div_r;
    logic [CH_N*GAIN_W-1:0] gain_r;
    logic [CNT_W-1:0]       n_r;
    logic [CNT_W-1:0]       m_r;
    logic                   dma_r;
    wire cfg_clear = hot_reset & ~hot_reset_config_jumper;

    always_ff @(posedge mclk)
    begin
        if (!rst_n || cfg_clear)
        begin
            mode_r     <= MODE_SINGLE;
            clk_src_r  <= CLK_INTERNAL;
            trg_src_r  <= TRG_SOFT;
            trg_fall_r <= 1'b0;
            div_r      <= DIV_RESET;
            gain_r     <= '0;
            n_r        <= CNT_ONE;
            m_r        <= CNT_TWO;
            dma_r      <= 1'b0;
        end
        else if (cfg_we)
        begin
            mode_r     <= cfg_mode;
            clk_src_r  <= cfg_clk_src;
            trg_src_r  <= cfg_trg_src;
            trg_fall_r <= cfg_trg_falling;
            div_r      <= cfg_divisor;
            gain_r     <= cfg_gain;
            n_r        <= cfg_count_n;
            m_r        <= cfg_count_m;
            dma_r      <= cfg_dma_en;
        end
    end

    // internal divider: a pulse every div_r+1 clocks; divisor 1 gives half rate
    logic [DIV_W-1:0] div_cnt_r;
    logic             int_tick_r;
    wire              div_wrap = (div_cnt_r == '0);
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            div_cnt_r  <= '0;
            int_tick_r <= 1'b0;
        end
        else
        begin
            div_cnt_r  <= div_wrap ? div_r : div_cnt_r - 8'h01;
            int_tick_r <= div_wrap;
        end
    end

    // external clocks are sampled; edge detect gives one pulse per rising edge
    logic ext_diff_d_r;
    logic ext_se_d_r;
    logic diff_gate_r;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ext_diff_d_r <= 1'b0;
            ext_se_d_r   <= 1'b0;
            diff_gate_r  <= 1'b0;
        end
        else
        begin
            ext_diff_d_r <= differential_ext_sample_clock;
            ext_se_d_r   <= single_ended_ext_sample_clock;
            if (differential_ext_sample_clock & ~ext_diff_d_r)
                diff_gate_r <= ~diff_gate_r;
        end
    end
    wire diff_rise = differential_ext_sample_clock & ~ext_diff_d_r;
    // differential clock acts as system clock: convert on every second edge only
    wire diff_tick = diff_rise & diff_gate_r;
    wire se_tick   = single_ended_ext_sample_clock & ~ext_se_d_r;
    wire samp_tick = (clk_src_r == CLK_EXT_DIFF) ? diff_tick :
                     (clk_src_r == CLK_EXT_SE)   ? se_tick   : int_tick_r;

    // trigger source and edge
    logic trg_lvl_d_r;
    wire  trg_lvl = (trg_src_r == TRG_EXT)    ? ext_trigger :
                    (trg_src_r == TRG_ANALOG) ? analog_above : sw_trigger;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            trg_lvl_d_r <= 1'b0;
        else
            trg_lvl_d_r <= trg_lvl;
    end
    wire trg_evt = trg_fall_r ? (~trg_lvl & trg_lvl_d_r) : (trg_lvl & ~trg_lvl_d_r);

    // sequencer
    mac_state_e       st_r;
    logic [CNT_W-1:0] cnt_r;
    // issued conversions counted apart from stored words: no stray word after the last in post and delay modes
    logic [CNT_W-1:0] iss_r;
    wire is_circ  = (mode_r == MODE_ABOUT) || (mode_r == MODE_PRE);
    wire needs_dma = (mode_r == MODE_POST) || (mode_r == MODE_DELAY);
    wire stored   = conv_done;
    wire cnt_last = (cnt_r == CNT_ONE);
    wire iss_left = (iss_r != CNT_ZERO);

    mac_state_e st_nxt;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] iss_nxt;
    logic fire;
    logic finish;
    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        iss_nxt = iss_r;
        fire    = 1'b0;
        finish  = 1'b0;
        unique case (st_r)
            MAC_IDLE:
            begin
                if (mode_r == MODE_SINGLE)
                    fire = sw_trigger;
                else if (sw_start && !(needs_dma && !dma_r))
                begin
                    unique case (mode_r)
                        MODE_PACER:              st_nxt = MAC_RUN;
                        MODE_POST, MODE_DELAY:   st_nxt = MAC_WAIT;
                        default:                 st_nxt = MAC_RUN;
                    endcase
                    cnt_nxt = (mode_r == MODE_DELAY) ? m_r : n_r;
                end
            end
            MAC_WAIT:
            begin
                if (trg_evt)
                begin
                    st_nxt  = (mode_r == MODE_DELAY) ? MAC_DELAY : MAC_POST;
                    iss_nxt = n_r;
                end
            end
            MAC_DELAY:
            begin
                if (samp_tick)
                begin
                    cnt_nxt = cnt_r - CNT_ONE;
                    if (cnt_last)
                    begin
                        st_nxt  = MAC_POST;
                        cnt_nxt = n_r;
                        iss_nxt = n_r;
                    end
                end
            end
            MAC_RUN:
            begin
                fire = samp_tick;
                if (mode_r == MODE_PRE && trg_evt)
                    finish = 1'b1;
                else if (mode_r == MODE_ABOUT && trg_evt)
                begin
                    st_nxt  = MAC_POST;
                    cnt_nxt = m_r;
                    iss_nxt = m_r;
                end
            end
            MAC_POST:
            begin
                fire    = samp_tick & iss_left;
                iss_nxt = fire ? iss_r - CNT_ONE : iss_r;
                if (stored)
                begin
                    cnt_nxt = cnt_r - CNT_ONE;
                    if (cnt_last)
                        finish = 1'b1;
                end
            end
            default:
                st_nxt = MAC_IDLE;
        endcase
        if (sw_stop || finish)
        begin
            st_nxt = MAC_IDLE;
            fire   = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            st_r       <= MAC_IDLE;
            cnt_r      <= CNT_ZERO;
            iss_r      <= CNT_ZERO;
            conv_start <= 1'b0;
            acq_busy   <= 1'b0;
            acq_done   <= 1'b0;
            dma_err    <= 1'b0;
            gain_out   <= '0;
        end
        else
        begin
            st_r       <= st_nxt;
            cnt_r      <= cnt_nxt;
            iss_r      <= iss_nxt;
            conv_start <= fire;
            acq_busy   <= (st_nxt != MAC_IDLE);
            acq_done   <= finish;
            dma_err    <= sw_start & needs_dma & ~dma_r & (st_r == MAC_IDLE);
            gain_out   <= gain_r;
        end
    end

    // two-entry skid buffer between converter and fifo; a full linear fifo stalls it
    logic [DATA_W-1:0] sk_d_r [2];
    logic              sk_v_r [2];
    logic              fifo_wr_ok;
    wire               sk_in_ready = ~sk_v_r[1];
    wire               sk_take     = conv_done & sk_in_ready;
    wire               sk_pop      = sk_v_r[0] & fifo_wr_ok;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sk_v_r[0] <= 1'b0;
            sk_v_r[1] <= 1'b0;
            sk_d_r[0] <= '0;
            sk_d_r[1] <= '0;
        end
        else if (sk_pop)
        begin
            sk_v_r[0] <= sk_v_r[1] | sk_take;
            sk_d_r[0] <= sk_v_r[1] ? sk_d_r[1] : conv_data;
            sk_v_r[1] <= sk_v_r[1] & sk_take;
            sk_d_r[1] <= conv_data;
        end
        else if (sk_take)
        begin
            if (!sk_v_r[0])
            begin
                sk_v_r[0] <= 1'b1;
                sk_d_r[0] <= conv_data;
            end
            else
            begin
                sk_v_r[1] <= 1'b1;
                sk_d_r[1] <= conv_data;
            end
        end
    end

    // result fifo; circular modes drop the oldest word rather than stall
    logic [DATA_W-1:0]  mem_r [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wp_r;
    logic [FIFO_AW-1:0] rp_r;
    logic [FIFO_AW:0]   lvl_r;
    wire is_full   = (lvl_r == 5'h10);
    wire is_empty  = (lvl_r == 5'h00);
    assign fifo_wr_ok = ~is_full | is_circ;
    wire drop_old  = sk_pop & is_full;
    wire do_rd     = rd_en & ~is_empty & ~drop_old;
    wire adv_rp    = do_rd | drop_old;
    wire lvl_up    = sk_pop & ~is_full;
    wire [FIFO_AW:0] lvl_nxt = (lvl_up && !do_rd) ? lvl_r + 5'h01 :
                               (do_rd && !lvl_up) ? lvl_r - 5'h01 : lvl_r;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wp_r           <= '0;
            rp_r           <= '0;
            lvl_r          <= '0;
            rd_data        <= '0;
            fifo_not_empty <= 1'b0;
            fifo_full      <= 1'b0;
        end
        else
        begin
            if (sk_pop)
            begin
                mem_r[wp_r] <= sk_d_r[0];
                wp_r        <= ptr_inc(wp_r);
            end
            if (adv_rp)
                rp_r <= ptr_inc(rp_r);
            if (do_rd)
                rd_data <= mem_r[rp_r];
            lvl_r          <= lvl_nxt;
            fifo_not_empty <= (lvl_nxt != 5'h00);
            fifo_full      <= (lvl_nxt == 5'h10);
        end
    end
endmodule : mac_acq
`default_nettype wire

// ### tb/mac_conv_model.sv
// Purpose: converter model answering conv_start with conv_done and a word
// Assumes: words count up from a known seed so the bench can predict them
// Notes:   off the done cycle the data bus shows the inverse, never the word
`timescale 1ns/1ps
`default_nettype none
module mac_conv_model
    import mac_pkg::*;
#(
    parameter int LAT = 2
)
(
    input  wire logic              mclk,
    input  wire logic              conv_start,
    output logic                   conv_done,
    output logic [DATA_W-1:0]      conv_data
);
    logic [DATA_W-1:0] seq_r  = 12'h5a0;
    logic [LAT-1:0]    pipe_r = '0;

    always @(posedge mclk)
    begin
        pipe_r <= {pipe_r[LAT-2:0], conv_start};
        if (pipe_r[LAT-1])
            seq_r <= seq_r + 12'h001;
    end
    assign conv_done = pipe_r[LAT-1];
    assign conv_data = conv_done ? seq_r : ~seq_r;
endmodule : mac_conv_model
`default_nettype wire

// ### tb/mac_acq_props.sv
// Purpose: port assertions for the acquisition sequencer
// Assumes: one clock, synchronous active-low reset
// Notes:   mode is mirrored from cfg_we so checks can be gated per mode
`timescale 1ns/1ps
`default_nettype none
module mac_acq_props
    import mac_pkg::*;
(
    input wire logic                   mclk,
    input wire logic                   rst_n,
    input wire logic                   hot_reset,
    input wire logic                   hot_reset_config_jumper,
    input wire logic                   cfg_we,
    input wire logic [2:0]             cfg_mode,
    input wire logic [CH_N*GAIN_W-1:0] cfg_gain,
    input wire logic                   sw_trigger,
    input wire logic                   sw_stop,
    input wire logic                   rd_en,
    input wire logic                   conv_done,
    input wire logic                   conv_start,
    input wire logic [CH_N*GAIN_W-1:0] gain_out,
    input wire logic                   fifo_not_empty,
    input wire logic                   fifo_full,
    input wire logic                   acq_busy,
    input wire logic                   acq_done,
    input wire logic                   dma_err
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [2:0] mode_r;

    always_ff @(posedge mclk)
        if (!rst_n || (hot_reset && !hot_reset_config_jumper))
            mode_r <= MODE_SINGLE;
        else if (cfg_we)
            mode_r <= cfg_mode;

    sequence s_word_in;
        conv_done && !rd_en && mode_r == MODE_SINGLE ##1 !rd_en ##1 !rd_en;
    endsequence

    a_reset_quiet: assert property ($rose(rst_n) |-> !acq_busy && !fifo_not_empty)
        else $error("outputs not quiet after reset");
    a_gain_load: assert property (cfg_we && !hot_reset |=> ##1 gain_out == $past(cfg_gain, 2))
        else $error("gain not loaded");
    a_hot_keep: assert property (hot_reset && hot_reset_config_jumper && !cfg_we
        |=> ##1 $stable(gain_out)) else $error("gain lost on kept hot reset");
    a_hot_clear: assert property (hot_reset && !hot_reset_config_jumper && !cfg_we
        |=> ##1 gain_out == '0) else $error("gain kept on clearing hot reset");
    a_single_conv: assert property (mode_r == MODE_SINGLE && sw_trigger && !cfg_we
        && !hot_reset |=> conv_start) else $error("no conversion on trigger");
    a_word_lands: assert property (s_word_in |-> ##[0:2] fifo_not_empty)
        else $error("word not shown in fifo");
    a_full_data: assert property (fifo_full |-> fifo_not_empty)
        else $error("full but empty");
    a_done_pulse: assert property (acq_done |=> !acq_done)
        else $error("done longer than one cycle");
    a_err_pulse: assert property (dma_err |=> !dma_err)
        else $error("dma error longer than one cycle");
    a_done_cause: assert property (acq_done && mode_r == MODE_POST && !$past(sw_stop)
        |-> $past(conv_done)) else $error("done without last word");
endmodule : mac_acq_props
`default_nettype wire

bind mac_acq mac_acq_props mac_acq_props_i (.mclk, .rst_n, .hot_reset,
    .hot_reset_config_jumper, .cfg_we, .cfg_mode, .cfg_gain, .sw_trigger, .sw_stop, .rd_en,
    .conv_done, .conv_start, .gain_out, .fifo_not_empty, .fifo_full, .acq_busy, .acq_done,
    .dma_err);

// ### tb/mac_acq_tb.sv
// Purpose: self-checking bench for the acquisition sequencer
// Assumes: converter model answers two cycles after conv_start
// Notes:   inputs change on the falling edge only
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module mac_acq_tb;
    import mac_pkg::*;
    logic mclk, rst_n, hot_reset, hot_reset_config_jumper, cfg_we, cfg_trg_falling;
    logic cfg_dma_en, sw_start, sw_stop, sw_trigger, ext_trigger, analog_above, rd_en;
    logic differential_ext_sample_clock, single_ended_ext_sample_clock, conv_start;
    logic conv_done, fifo_not_empty, fifo_full, acq_busy, acq_done, dma_err;
    logic [2:0]  cfg_mode;
    logic [1:0]  cfg_clk_src, cfg_trg_src;
    logic [7:0]  cfg_divisor, cfg_gain, gain_out;
    logic [16:0] cfg_count_n, cfg_count_m;
    logic [11:0] conv_data, rd_data, exp_w;
    int          mismatches, n_tests, cyc, n_conv;

    mac_acq mac_acq_i (.mclk, .rst_n, .hot_reset, .hot_reset_config_jumper, .cfg_we,
        .cfg_mode, .cfg_clk_src, .cfg_trg_src, .cfg_trg_falling, .cfg_divisor, .cfg_gain,
        .cfg_count_n, .cfg_count_m, .cfg_dma_en, .sw_start, .sw_stop, .sw_trigger,
        .ext_trigger, .analog_above, .differential_ext_sample_clock,
        .single_ended_ext_sample_clock, .conv_start, .conv_done, .conv_data, .gain_out,
        .rd_en, .rd_data, .fifo_not_empty, .fifo_full, .acq_busy, .acq_done, .dma_err);
    mac_conv_model mac_conv_model_i (.mclk, .conv_start, .conv_done, .conv_data);

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (conv_start === 1'b1) n_conv++;
        if (cyc == 10000)
        begin
            mismatches++;
            final_report();
        end
    end
    // external clocks run free: single-ended period 8, differential period 4
    always @(negedge mclk)
    begin
        single_ended_ext_sample_clock <= cyc[2];
        differential_ext_sample_clock <= cyc[1];
    end

    task automatic final_report;
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick
    task automatic set_cfg(input logic [2:0] m, input logic [7:0] dv, input logic [16:0] n);
        cfg_mode = m;
        cfg_divisor = dv;
        cfg_count_n = n;
        cfg_we = 1'b1;
        tick(1);
        cfg_we = 1'b0;
        tick(1);
    endtask : set_cfg
    task automatic start_acq;
        sw_start = 1'b1;
        tick(1);
        sw_start = 1'b0;
    endtask : start_acq
    task automatic set_trg(input logic [1:0] s, input logic v);
        if (s == TRG_EXT) ext_trigger = v;
        else if (s == TRG_ANALOG) analog_above = v;
        else sw_trigger = v;
    endtask : set_trg
    task automatic drain(input bit chk, output int cnt);
        cnt = 0;
        while (fifo_not_empty === 1'b1 && cnt < 40)
        begin
            rd_en = 1'b1;
            tick(1);
            rd_en = 1'b0;
            if (chk) `CHK("rd_data", exp_w, rd_data)
            exp_w = exp_w + 12'h001;
            cnt++;
            tick(2);
        end
        exp_w = mac_conv_model_i.seq_r;
    endtask : drain

    task automatic t_gain;
        set_cfg(MODE_SINGLE, 8'h00, 17'h00001);
        `CHK("gain", 8'he4, gain_out)
        hot_reset_config_jumper = 1'b1;
        hot_reset = 1'b1;
        tick(1);
        hot_reset = 1'b0;
        tick(1);
        `CHK("gain_kept", 8'he4, gain_out)
        hot_reset_config_jumper = 1'b0;
        hot_reset = 1'b1;
        tick(1);
        hot_reset = 1'b0;
        tick(1);
        `CHK("gain_cleared", 8'h00, gain_out)
    endtask : t_gain
    task automatic t_single;
        int base;
        int cnt;
        set_cfg(MODE_SINGLE, 8'h00, 17'h00001);
        base = n_conv;
        sw_trigger = 1'b1;
        tick(1);
        sw_trigger = 1'b0;
        `CHK("conv_start", 1'b1, conv_start)
        tick(8);
        `CHK("one_conv", base + 1, n_conv)
        drain(1'b1, cnt);
        `CHK("single_words", 1, cnt)
    endtask : t_single
    task automatic t_dma;
        cfg_dma_en = 1'b0;
        set_cfg(MODE_POST, 8'h01, 17'h00004);
        start_acq();
        for (int i = 0; i < 4 && dma_err !== 1'b1; i++) tick(1);
        `CHK("dma_err", 1'b1, dma_err)
        tick(4);
        `CHK("refused", 1'b0, acq_busy)
        cfg_dma_en = 1'b1;
    endtask : t_dma
    task automatic t_run(input logic [2:0] m, input logic [1:0] s, input logic f);
        int base;
        int cnt;
        set_trg(s, f);
        cfg_trg_src = s;
        cfg_trg_falling = f;
        cfg_clk_src = CLK_INTERNAL;
        // pre mode: host asks for 14 kept words as 14 plus two
        set_cfg(m, 8'h01, (m == MODE_PRE) ? 17'd16 : 17'd4);
        base = n_conv;
        start_acq();
        tick(60);
        if (m < MODE_ABOUT) `CHK("idle_before_trig", base, n_conv)
        else `CHK("wrap_full", 1'b1, fifo_full)
        set_trg(s, !f);
        for (int i = 0; i < 300 && acq_done !== 1'b1; i++) tick(1);
        `CHK("acq_done", 1'b1, acq_done)
        tick(6);
        set_trg(s, 1'b0);
        `CHK("idle_after", 1'b0, acq_busy)
        if (m == MODE_POST) `CHK("post_convs", base + 4, n_conv)
        drain(m == MODE_POST, cnt);
        if (m < MODE_ABOUT) `CHK("stored", 4, cnt)
    endtask : t_run
    task automatic t_pacer(input logic [1:0] cs, input logic [7:0] dv, input int gap);
        int t0;
        int cnt;
        cfg_clk_src = cs;
        set_cfg(MODE_PACER, dv, 17'h00001);
        start_acq();
        for (int i = 0; i < 50 && conv_start !== 1'b1; i++) tick(1);
        t0 = cyc;
        tick(1);
        for (int i = 0; i < 50 && conv_start !== 1'b1; i++) tick(1);
        `CHK("pace_gap", gap, cyc - t0)
        tick(200);
        `CHK("fifo_full", 1'b1, fifo_full)
        sw_stop = 1'b1;
        tick(1);
        sw_stop = 1'b0;
        tick(6);
        drain(1'b0, cnt);
        `CHK("drained", 1'b0, fifo_not_empty)
    endtask : t_pacer

    initial
    begin
        {rst_n, hot_reset, hot_reset_config_jumper, cfg_we, cfg_trg_falling} = '0;
        {sw_start, sw_stop, sw_trigger, ext_trigger, analog_above, rd_en} = '0;
        {cfg_mode, cfg_clk_src, cfg_trg_src, cfg_divisor, cfg_count_n} = '0;
        cfg_dma_en = 1'b1;
        cfg_gain = 8'he4;
        cfg_count_m = 17'd2;
        exp_w = 12'h5a0;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        tick(1);
        t_gain();
        t_single();
        t_dma();
        t_run(MODE_POST, TRG_SOFT, 1'b0);
        t_run(MODE_POST, TRG_EXT, 1'b0);
        t_run(MODE_DELAY, TRG_ANALOG, 1'b1);
        t_run(MODE_ABOUT, TRG_EXT, 1'b1);
        t_run(MODE_PRE, TRG_SOFT, 1'b0);
        t_pacer(CLK_INTERNAL, 8'h03, 4);
        t_pacer(CLK_EXT_SE, 8'h00, 8);
        t_pacer(CLK_EXT_DIFF, 8'h00, 8);
        final_report();
    end
endmodule : mac_acq_tb
`default_nettype wire
